// ==== hw/xmc_ctrl.sv ====
// Purpose: external memory interface configuration, access sequencer and pin steering
// Assumes: one clock, the core issues one external access at a time
// Notes: pin outputs are registered and follow the sequencer state
`timescale 1ns/1ns
module xmc_ctrl
    import xmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // legacy compatibility strap, same clock domain
    input wire logic compat_mode,
    // register access from the core
    input wire logic acc_io,
    input wire logic [15:0] acc_addr,
    input wire logic acc_we,
    input wire logic acc_re,
    input wire logic [7:0] acc_wdata,
    output logic [7:0] acc_rdata,
    output logic acc_hit,
    // external access request from the core
    input wire logic mem_req,
    output logic mem_ready,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic mem_resp_valid,
    output logic [7:0] mem_rdata,
    // port settings that own the pins when the interface does not
    input wire logic [7:0] porta_out,
    input wire logic [7:0] porta_ddr,
    input wire logic [7:0] portc_out,
    input wire logic [7:0] portc_ddr,
    input wire logic [2:0] portg_out,
    input wire logic [2:0] portg_ddr,
    // multiplexed address/data pins
    input wire logic [7:0] muxed_addr_data_lines_i,
    output logic [7:0] muxed_addr_data_lines_o,
    output logic [7:0] muxed_addr_data_lines_oe,
    // bus keeper, weak drive on the same pins
    output logic [7:0] keeper_o,
    output logic [7:0] keeper_oe,
    // high address pins (port c)
    output logic [7:0] high_addr_lines_o,
    output logic [7:0] high_addr_lines_oe,
    // latch and strobes (port g bits 2..0: latch, read, write)
    output logic addr_latch_o,
    output logic addr_latch_oe,
    output logic read_strobe_n_o,
    output logic read_strobe_n_oe,
    output logic write_strobe_n_o,
    output logic write_strobe_n_oe
);

    typedef enum logic [2:0] {
        XMC_IDLE,
        XMC_ADDR,
        XMC_LATCH,
        XMC_STROBE,
        XMC_HOLD
    } xmc_state_type;

    // upper sector start for a limit code
    function automatic logic [15:0] sector_start(input logic [2:0] limit);
        if (limit == 3'h0) begin
            sector_start = EXT_SPACE_BASE;
        end else begin
            sector_start = {limit, 13'h0000};
        end
    endfunction

    // pins kept for the high address byte; the rest go back to the port
    function automatic logic [7:0] hi_keep_mask(input logic [2:0] mask);
        if (mask == HMASK_NONE_LEFT) begin
            hi_keep_mask = 8'h00;
        end else begin
            hi_keep_mask = 8'hff >> mask;
        end
    endfunction

    // register file
    logic [7:0] main_ctrl, keep_mask, wait_sect;

    xmc_regs u_regs (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .acc_io(acc_io),
        .acc_addr(acc_addr),
        .acc_we(acc_we),
        .acc_re(acc_re),
        .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata),
        .acc_hit(acc_hit),
        .main_ctrl(main_ctrl),
        .keep_mask(keep_mask),
        .wait_sect(wait_sect)
    );

    // data pins are asynchronous to us
    logic [7:0] ad_sync;

    xmc_sync #(
        .WIDTH(8)
    ) u_ad_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .din(muxed_addr_data_lines_i),
        .dout(ad_sync)
    );

    // decoded configuration
    logic ext_iface_enable, upper_wait_low_bit, upper_wait_high_bit, bus_keeper_enable;
    logic [2:0] sector_limit_sel, high_addr_mask;
    logic [1:0] lower_wait_sel, upper_wait, access_wait;
    logic [7:0] hi_drive;

    always_comb begin
        ext_iface_enable = main_ctrl[ENABLE_BIT];
        upper_wait_low_bit = main_ctrl[UWAIT_LO_BIT];
        upper_wait_high_bit = wait_sect[UWAIT_HI_BIT];
        sector_limit_sel = wait_sect[LIMIT_LSB +: 3];
        lower_wait_sel = wait_sect[LOWER_WAIT_LSB +: 2];
        bus_keeper_enable = keep_mask[KEEPER_BIT];
        high_addr_mask = keep_mask[HMASK_LSB +: 3];
        hi_drive = hi_keep_mask(high_addr_mask); // RULE12 RULE13
        upper_wait = {upper_wait_high_bit, upper_wait_low_bit}; // RULE8
        if (compat_mode) begin
            access_wait = {1'b0, upper_wait_low_bit}; // RULE4
        end else if (mem_addr >= sector_start(sector_limit_sel)) begin // RULE5 RULE6
            access_wait = upper_wait; // RULE16
        end else begin
            access_wait = lower_wait_sel; // RULE7 RULE16
        end
    end

    // access sequencer
    xmc_state_type state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] wait_q, wait_d;
    logic we_q, we_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic resp_q, resp_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wait_d = wait_q;
        we_d = we_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        resp_d = 1'b0;
        mem_ready = (state_q == XMC_IDLE) && ext_iface_enable;
        case (state_q)
            XMC_IDLE: begin
                if (mem_req && ext_iface_enable) begin
                    state_d = XMC_ADDR;
                    wait_d = access_wait;
                    we_d = mem_we;
                    addr_d = mem_addr;
                    wdata_d = mem_wdata;
                end
            end
            XMC_ADDR: begin
                state_d = XMC_LATCH;
            end
            XMC_LATCH: begin
                state_d = XMC_STROBE;
                // reads stay low long enough for the pin synchroniser
                cnt_d = STROBE_BASE_CYCLES + {2'b00, wait_q[1] ? 2'h2 : {1'b0, wait_q[0]}} // RULE9
                    + (we_q ? 4'h0 : SYNC_READ_EXTRA);
            end
            XMC_STROBE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    resp_d = 1'b1;
                    if (!we_q) begin
                        rdata_d = ad_sync;
                    end
                    state_d = (wait_q == WAIT_TWO_HOLD) ? XMC_HOLD : XMC_IDLE; // RULE9
                end
            end
            XMC_HOLD: begin
                state_d = XMC_IDLE;
            end
            default: begin
                state_d = XMC_IDLE;
            end
        endcase
        // a disabled interface drops any access in flight
        if (!ext_iface_enable) begin
            state_d = XMC_IDLE; // RULE3
            resp_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= XMC_IDLE;
            cnt_q <= 4'h0;
            wait_q <= 2'h0;
            we_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            resp_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wait_q <= wait_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    assign mem_resp_valid = resp_q;
    assign mem_rdata = rdata_q;

    // pin steering, computed from the next sequencer state
    logic [7:0] ad_o_q, ad_o_d, ad_oe_q, ad_oe_d;
    logic [7:0] hi_o_q, hi_o_d, hi_oe_q, hi_oe_d;
    logic [7:0] keep_o_q, keep_o_d, keep_oe_q, keep_oe_d;
    logic [2:0] g_o_q, g_o_d, g_oe_q, g_oe_d;
    logic strobe_next;

    always_comb begin
        strobe_next = (state_d == XMC_STROBE);
        if (ext_iface_enable) begin
            // interface owns the pins regardless of direction settings
            ad_o_d = (state_d == XMC_STROBE) ? wdata_d : addr_d[7:0]; // RULE1 RULE2
            ad_oe_d = 8'h00;
            if ((state_d == XMC_ADDR) || (state_d == XMC_LATCH) || (strobe_next && we_d)) begin
                ad_oe_d = 8'hff;
            end
            hi_o_d = (addr_d[15:8] & hi_drive) | (portc_out & ~hi_drive); // RULE12 RULE13
            hi_oe_d = hi_drive | (portc_ddr & ~hi_drive); // RULE13
            g_o_d = {state_d == XMC_ADDR, !(strobe_next && !we_d), !(strobe_next && we_d)};
            g_oe_d = 3'h7; // RULE2
        end else begin
            ad_o_d = porta_out; // RULE3
            ad_oe_d = porta_ddr;
            hi_o_d = portc_out;
            hi_oe_d = portc_ddr;
            g_o_d = portg_out;
            g_oe_d = portg_ddr;
        end
        // keeper remembers the last defined level on each line
        keep_o_d = (ad_oe_q & ad_o_q) | (~ad_oe_q & ad_sync); // RULE10
        keep_oe_d = bus_keeper_enable ? ~ad_oe_d : 8'h00; // RULE10 RULE11
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ad_o_q <= 8'h00;
            ad_oe_q <= 8'h00;
            hi_o_q <= 8'h00;
            hi_oe_q <= 8'h00;
            keep_o_q <= 8'h00;
            keep_oe_q <= 8'h00;
            g_o_q <= 3'h0;
            g_oe_q <= 3'h0;
        end else if (ce) begin
            ad_o_q <= ad_o_d;
            ad_oe_q <= ad_oe_d;
            hi_o_q <= hi_o_d;
            hi_oe_q <= hi_oe_d;
            keep_o_q <= keep_o_d;
            keep_oe_q <= keep_oe_d;
            g_o_q <= g_o_d;
            g_oe_q <= g_oe_d;
        end
    end

    assign muxed_addr_data_lines_o = ad_o_q;
    assign muxed_addr_data_lines_oe = ad_oe_q;
    assign keeper_o = keep_o_q;
    assign keeper_oe = keep_oe_q;
    assign high_addr_lines_o = hi_o_q;
    assign high_addr_lines_oe = hi_oe_q;
    assign addr_latch_o = g_o_q[2];
    assign addr_latch_oe = g_oe_q[2];
    assign read_strobe_n_o = g_o_q[1];
    assign read_strobe_n_oe = g_oe_q[1];
    assign write_strobe_n_o = g_o_q[0];
    assign write_strobe_n_oe = g_oe_q[0];

endmodule

// ==== hw/xmc_pkg.sv ====
// Purpose: shared constants for the external memory interface configuration block
// Assumes: 8-bit core data path, 16-bit data-space addresses
// Notes: register bit positions, decode addresses and timing counts live here
//
// Summary of operation
// RULE1 - enable bit hands AD, high address, ALE, RD and WR pins to the interface
// RULE2 - while enabled, interface pin control overrides port direction settings
// RULE3 - clearing enable returns all those pins to plain port control
// RULE4 - legacy mode: single wait bit adds one strobe cycle to every access
// RULE5 - three-bit limit field sets upper sector start at 0x2000 steps
// RULE6 - limit zero makes one sector using the upper-sector wait bits
// RULE7 - two-bit lower wait field applies to lower-sector accesses
// RULE8 - upper wait value is high bit from wait register, low from main
// RULE9 - wait codes: none, one, two, two plus one before next address
// RULE10 - keeper enable holds undriven AD lines at their last level
// RULE11 - keeper works whether or not the interface is enabled
// RULE12 - enabled with mask zero drives all eight high address pins
// RULE13 - mask 1..7 releases high address pins from pin 7 downward
// RULE14 - main register at I/O 0x35 and data address 0x55
// RULE15 - the two extended registers answer only data-space accesses
// RULE16 - address below boundary uses lower wait, at or above uses upper
package xmc_pkg;

    // decode addresses
    localparam logic [15:0] IO_SPACE_TOP = 16'h0040;
    localparam logic [15:0] MAIN_IO_ADDR = 16'h0035;
    localparam logic [15:0] MAIN_DS_ADDR = 16'h0055;
    localparam logic [15:0] KEEPMASK_DS_ADDR = 16'h006c;
    localparam logic [15:0] WAITSEC_DS_ADDR = 16'h006d;

    // reset values and writable bits
    localparam logic [7:0] MAIN_RESET = 8'h00;
    localparam logic [7:0] KEEPMASK_RESET = 8'h00;
    localparam logic [7:0] WAITSEC_RESET = 8'h00;
    localparam logic [7:0] MAIN_WMASK = 8'hc0;
    localparam logic [7:0] KEEPMASK_WMASK = 8'h87;
    localparam logic [7:0] WAITSEC_WMASK = 8'h7e;

    // field positions
    localparam int ENABLE_BIT = 7;
    localparam int UWAIT_LO_BIT = 6;
    localparam int LIMIT_LSB = 4;
    localparam int LOWER_WAIT_LSB = 2;
    localparam int UWAIT_HI_BIT = 1;
    localparam int KEEPER_BIT = 7;
    localparam int HMASK_LSB = 0;

    // address space
    localparam logic [15:0] EXT_SPACE_BASE = 16'h1100;
    localparam logic [2:0] HMASK_NONE_LEFT = 3'h7;

    // wait codes
    localparam logic [1:0] WAIT_TWO_HOLD = 2'h3;

    // timing counts in clock cycles
    localparam logic [3:0] STROBE_BASE_CYCLES = 4'h1;
    localparam logic [3:0] SYNC_READ_EXTRA = 4'h4;

endpackage

// ==== hw/xmc_regs.sv ====
// Purpose: the three configuration registers and their address decode
// Assumes: one access per cycle from the core, read data one cycle later
// Notes: unmapped addresses read zero and ignore writes
`timescale 1ns/1ns
module xmc_regs
    import xmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // core access
    input wire logic acc_io,
    input wire logic [15:0] acc_addr,
    input wire logic acc_we,
    input wire logic acc_re,
    input wire logic [7:0] acc_wdata,
    output logic [7:0] acc_rdata,
    output logic acc_hit,
    // register contents
    output logic [7:0] main_ctrl,
    output logic [7:0] keep_mask,
    output logic [7:0] wait_sect
);

    logic [7:0] main_q, main_d, km_q, km_d, ws_q, ws_d, rdata_q, rdata_d;
    logic hit_main, hit_km, hit_ws;

    always_comb begin
        hit_main = acc_io ? (acc_addr == MAIN_IO_ADDR) : (acc_addr == MAIN_DS_ADDR); // RULE14
        hit_km = !acc_io && (acc_addr == KEEPMASK_DS_ADDR); // RULE15
        hit_ws = !acc_io && (acc_addr == WAITSEC_DS_ADDR); // RULE15
        acc_hit = hit_main | hit_km | hit_ws;
        main_d = main_q;
        km_d = km_q;
        ws_d = ws_q;
        if (acc_we && hit_main) begin
            main_d = (main_q & ~MAIN_WMASK) | (acc_wdata & MAIN_WMASK);
        end
        if (acc_we && hit_km) begin
            km_d = (km_q & ~KEEPMASK_WMASK) | (acc_wdata & KEEPMASK_WMASK);
        end
        if (acc_we && hit_ws) begin
            ws_d = (ws_q & ~WAITSEC_WMASK) | (acc_wdata & WAITSEC_WMASK);
        end
        rdata_d = rdata_q;
        if (acc_re) begin
            rdata_d = hit_main ? main_q : hit_km ? km_q : hit_ws ? ws_q : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            main_q <= MAIN_RESET;
            km_q <= KEEPMASK_RESET;
            ws_q <= WAITSEC_RESET;
            rdata_q <= 8'h00;
        end else if (ce) begin
            main_q <= main_d;
            km_q <= km_d;
            ws_q <= ws_d;
            rdata_q <= rdata_d;
        end
    end

    assign acc_rdata = rdata_q;
    assign main_ctrl = main_q;
    assign keep_mask = km_q;
    assign wait_sect = ws_q;

endmodule

// ==== hw/xmc_sync.sv ====
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs come from pins outside the clock domain
// Notes: output updates only when stages two and three agree
`timescale 1ns/1ns
module xmc_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_q, s2_q, s3_q, dout_q;
    logic [WIDTH-1:0] dout_d;

    always_comb begin
        // per bit, a disagreement keeps the old value
        dout_d = (dout_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            dout_q <= '0;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            dout_q <= dout_d;
        end
    end

    assign dout = dout_q;

endmodule

// ==== tb/xmc_ctrl_properties.sv ====
// Purpose: port checker for xmc_ctrl
// Assumes: ce held high, port g read direction cleared
// Notes: bound to every xmc_ctrl instance
`timescale 1ns/1ns
module xmc_ctrl_chk (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // access handshake
    input wire logic mem_req,
    input wire logic mem_ready,
    input wire logic mem_we,
    input wire logic mem_resp_valid,
    // pins
    input wire logic [7:0] muxed_addr_data_lines_oe,
    input wire logic [7:0] keeper_oe,
    input wire logic addr_latch_o,
    input wire logic addr_latch_oe,
    input wire logic read_strobe_n_o,
    input wire logic read_strobe_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic tk = mem_req && mem_ready;
    chk_wr_time: assert property (tk && mem_we |-> ##[4:6] mem_resp_valid)
        else $error("write response out of window");
    chk_rd_time: assert property (tk && !mem_we |-> ##[8:10] mem_resp_valid)
        else $error("read response out of window");
    chk_no_early: assert property (tk |=> !mem_resp_valid [*3])
        else $error("response too early");
    chk_busy_taken: assert property (tk |=> !mem_ready)
        else $error("ready while busy");
    chk_resp_pulse: assert property (mem_resp_valid |=> !mem_resp_valid)
        else $error("response longer than one cycle");
    chk_keep_drive: assert property ((keeper_oe & muxed_addr_data_lines_oe) == 8'h00)
        else $error("keeper fights strong drive");
    chk_latch_addr: assert property ($rose(addr_latch_o) |-> muxed_addr_data_lines_oe == 8'hff)
        else $error("address not driven at latch");
    chk_read_float: assert property (read_strobe_n_oe && !read_strobe_n_o
        |-> muxed_addr_data_lines_oe == 8'h00)
        else $error("bus driven during read");
    chk_ready_owns: assert property (mem_ready |=> addr_latch_oe)
        else $error("latch pin not owned");
endmodule

bind xmc_ctrl xmc_ctrl_chk u_chk (
    .clk(clk),
    .resetn(resetn),
    .mem_req(mem_req),
    .mem_ready(mem_ready),
    .mem_we(mem_we),
    .mem_resp_valid(mem_resp_valid),
    .muxed_addr_data_lines_oe(muxed_addr_data_lines_oe),
    .keeper_oe(keeper_oe),
    .addr_latch_o(addr_latch_o),
    .addr_latch_oe(addr_latch_oe),
    .read_strobe_n_o(read_strobe_n_o),
    .read_strobe_n_oe(read_strobe_n_oe)
);

// ==== tb/xmc_ctrl_tb.sv ====
// Purpose: self-checking bench for xmc_ctrl
// Assumes: ce tied high, port g outputs held low
// Notes: memory model answers after a short delay
`timescale 1ns/1ns
module xmc_ctrl_tb
    import xmc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic compat_mode = 1'b0;
    logic acc_io = 1'b0;
    logic acc_we = 1'b0;
    logic acc_re = 1'b0;
    logic mem_req = 1'b0;
    logic mem_we = 1'b0;
    logic [15:0] acc_addr = 16'h0000;
    logic [15:0] mem_addr = 16'h0000;
    logic [7:0] acc_wdata = 8'h00;
    logic [7:0] mem_wdata = 8'h00;
    logic [7:0] pa_o = 8'h00;
    logic [7:0] pa_d = 8'h00;
    logic [7:0] pc_o = 8'h00;
    logic [7:0] pc_d = 8'h00;
    logic [2:0] pg_d = 3'h0;
    logic hit_seen = 1'b0;
    logic [7:0] acc_rdata, mem_rdata, ad_o, ad_oe, kp_o, kp_oe, hi_o, hi_oe, dq;
    logic acc_hit, mem_ready, resp, lat_o, lat_oe, rd_o, rd_oe, wr_o, wr_oe, dq_oe;
    int err_total = 0;
    int n_compared = 0;
    // strong drive wins over memory, keeper only holds an otherwise floating line
    wire logic [7:0] ad_i = (ad_o & ad_oe)
        | (~ad_oe & (dq_oe ? dq : ((kp_o & kp_oe) | (dq & ~kp_oe))));
    wire logic rd_n = rd_oe ? rd_o : 1'b1;
    wire logic wr_n = wr_oe ? wr_o : 1'b1;

    always #5 clk = ~clk;

    xmc_ctrl uut (
        .clk(clk),
        .resetn(resetn),
        .ce(1'b1),
        .compat_mode(compat_mode),
        .acc_io(acc_io),
        .acc_addr(acc_addr),
        .acc_we(acc_we),
        .acc_re(acc_re),
        .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata),
        .acc_hit(acc_hit),
        .mem_req(mem_req),
        .mem_ready(mem_ready),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_resp_valid(resp),
        .mem_rdata(mem_rdata),
        .porta_out(pa_o),
        .porta_ddr(pa_d),
        .portc_out(pc_o),
        .portc_ddr(pc_d),
        .portg_out(3'h0),
        .portg_ddr(pg_d),
        .muxed_addr_data_lines_i(ad_i),
        .muxed_addr_data_lines_o(ad_o),
        .muxed_addr_data_lines_oe(ad_oe),
        .keeper_o(kp_o),
        .keeper_oe(kp_oe),
        .high_addr_lines_o(hi_o),
        .high_addr_lines_oe(hi_oe),
        .addr_latch_o(lat_o),
        .addr_latch_oe(lat_oe),
        .read_strobe_n_o(rd_o),
        .read_strobe_n_oe(rd_oe),
        .write_strobe_n_o(wr_o),
        .write_strobe_n_oe(wr_oe)
    );

    xmc_sram_model #(.DLY(3)) u_mem (
        .clk(clk),
        .ad_pin(ad_i),
        .hi_pin(hi_o),
        .latch(lat_o),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .dq(dq),
        .dq_oe(dq_oe)
    );

    task tick;
        @(posedge clk);
        #1;
    endtask

    task cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task cmpc(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            err_total++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    function automatic int wt(input logic [1:0] c);
        return (c == 2'h0) ? 0 : (c == 2'h1) ? 1 : 2;
    endfunction

    // strobe lowered one cycle later so back-to-back calls never re-raise it in one step
    task wr(input logic io, input logic [15:0] a, input logic [7:0] d);
        acc_io = io;
        acc_addr = a;
        acc_wdata = d;
        acc_we = 1'b1;
        tick;
        acc_we = 1'b0;
        tick;
    endtask

    task rd(input logic io, input logic [15:0] a, output logic [7:0] d);
        acc_io = io;
        acc_addr = a;
        acc_re = 1'b1;
        tick;
        acc_re = 1'b0;
        d = acc_rdata;
        hit_seen = acc_hit;
        tick;
    endtask

    task mem_op(input logic we, input logic [15:0] a, input logic [7:0] d, input int w);
        int n;
        n = 0;
        mem_we = we;
        mem_addr = a;
        mem_wdata = d;
        mem_req = 1'b1;
        while (mem_ready !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        tick;
        mem_req = 1'b0;
        n = 0;
        while (resp !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        // n counts edges after the take edge up to the one that launches the pulse
        cmpc("access cycles", we ? 3 + w : 7 + w, n);
        if (!we) cmp8("read data", d, mem_rdata);
        tick;
    endtask

    task t_regs;
        logic [15:0] ra [3];
        logic [7:0] rm [3];
        logic [7:0] v;
        ra = '{16'h0055, 16'h006c, 16'h006d};
        rm = '{MAIN_WMASK, KEEPMASK_WMASK, WAITSEC_WMASK};
        for (int i = 0; i < 3; i++) begin
            rd(1'b0, ra[i], v);
            cmp8("reg reset", 8'h00, v);
            cmp8("reg hit", 8'h01, {7'h00, hit_seen});
            wr(1'b0, ra[i], 8'hff);
            rd(1'b0, ra[i], v);
            cmp8("reg rw", rm[i], v);
        end
        rd(1'b1, 16'h0035, v);
        cmp8("main io", 8'hc0, v);
        rd(1'b1, 16'h006d, v);
        cmp8("ext via io", 8'h00, v);
        cmp8("ext hit via io", 8'h00, {7'h00, hit_seen});
        rd(1'b0, 16'h0060, v);
        cmp8("unmapped", 8'h00, v);
        for (int i = 0; i < 3; i++) wr(1'b0, ra[i], 8'h00);
        $display("regs done");
    endtask

    task t_pins;
        logic [7:0] e;
        pa_o = 8'h5a;
        pa_d = 8'h3c;
        pc_o = 8'ha5;
        pc_d = 8'h0f;
        pg_d = 3'h5;
        tick;
        cmp8("ad oe off", 8'h3c, ad_oe);
        cmp8("ad out off", 8'h5a, ad_o);
        cmp8("hi oe off", 8'h0f, hi_oe);
        wr(1'b1, 16'h0035, 8'h80);
        for (int m = 0; m < 8; m++) begin
            e = (m == 7) ? 8'h00 : 8'hff >> m;
            wr(1'b0, 16'h006c, {5'h00, m[2:0]});
            cmp8("hi oe", e | (pc_d & ~e), hi_oe);
            cmp8("hi released", pc_o & ~e, hi_o & ~e);
            cmp8("ctl oe", 8'h07, {5'h00, lat_oe, rd_oe, wr_oe});
        end
        wr(1'b1, 16'h0035, 8'h00);
        cmp8("ctl oe off", 8'h05, {5'h00, lat_oe, rd_oe, wr_oe});
        cmp8("hi back", 8'h0f, hi_oe);
        wr(1'b0, 16'h006c, 8'h80);
        cmp8("keeper idle", 8'hc3, kp_oe);
        cmp8("keeper level", 8'h18, kp_o & 8'h3c);
        wr(1'b0, 16'h006c, 8'h00);
        cmp8("keeper off", 8'h00, kp_oe);
        pa_d = 8'h00;
        pg_d = 3'h0;
        $display("pins done");
    endtask

    task t_sect;
        logic [1:0] lc, uc;
        logic [15:0] b;
        for (int l = 0; l < 8; l++) begin
            lc = l[1:0];
            uc = 2'h3 - lc;
            b = (l == 0) ? 16'h1100 : {l[2:0], 13'h0000};
            wr(1'b1, 16'h0035, {1'b1, uc[0], 6'h00});
            wr(1'b0, 16'h006d, {1'b0, l[2:0], lc, uc[1], 1'b0});
            if (l != 0) begin
                mem_op(1'b1, b - 16'h0001, b[15:8] ^ 8'h3c, wt(lc));
                mem_op(1'b0, b - 16'h0001, b[15:8] ^ 8'h3c, wt(lc));
            end
            mem_op(1'b1, b, b[15:8], wt(uc));
            mem_op(1'b0, b, b[15:8], wt(uc));
        end
        $display("sectors done");
    endtask

    task t_compat;
        compat_mode = 1'b1;
        wr(1'b0, 16'h006d, 8'h7e);
        wr(1'b1, 16'h0035, 8'hc0);
        mem_op(1'b1, 16'h3000, 8'h77, 1);
        mem_op(1'b0, 16'h3000, 8'h77, 1);
        wr(1'b1, 16'h0035, 8'h80);
        mem_op(1'b1, 16'h3001, 8'h88, 0);
        compat_mode = 1'b0;
        tick;
        $display("compat done");
    endtask

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out;
    end

    initial begin
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        tick;
        t_regs;
        t_pins;
        t_sect;
        t_compat;
        close_out;
    end
endmodule

// ==== tb/xmc_sram_model.sv ====
// Purpose: asynchronous byte memory on the multiplexed bus
// Assumes: strobes resolved to inactive high when undriven
// Notes: released bus shows inverse of last value, not a stale copy
`timescale 1ns/1ns
module xmc_sram_model #(
    parameter int DLY = 1
) (
    // clock used to sample latch and write
    input wire logic clk,
    // bus seen by the memory
    input wire logic [7:0] ad_pin,
    input wire logic [7:0] hi_pin,
    input wire logic latch,
    input wire logic rd_n,
    input wire logic wr_n,
    // memory drive
    output logic [7:0] dq,
    output logic dq_oe
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr = 16'h0000;
    logic [7:0] last = 8'h00;
    logic oe_d = 1'b0;
    always @(rd_n) oe_d <= #DLY !rd_n;
    assign dq_oe = oe_d;
    assign dq = oe_d ? mem[addr] : ~last;
    always @(posedge clk) begin
        if (latch) addr <= {hi_pin, ad_pin};
        if (!wr_n) mem[addr] <= ad_pin;
        if (oe_d) last <= mem[addr];
    end
endmodule
